/* logic/cirp_ctrl_end.sv */
// controller end: drives requests and bus terminations under axi4-lite control
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cirp_ctrl_end (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // link to the core
  cirp_if.ctl link,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ========================================
  // address decode
  function automatic logic [3:0] word_off(input logic [31:0] a);
    word_off = {a[3:2], 2'b00};
  endfunction
  function automatic logic mapped(input logic [31:0] a);
    mapped = a[31:4] == '0;
  endfunction

  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [2:0] resp_code;
  logic iack_seen;
  wire aw_ok = ~s_axi_awready;
  wire w_ok = ~s_axi_wready;
  wire do_write = aw_ok & w_ok & ~s_axi_bvalid;
  wire wr_map = mapped(aw_addr);
  wire [3:0] wr_off = word_off(aw_addr);
  wire wr_ctrl = do_write & wr_map & wr_off == cirp_pkg::OFF_CTRL;
  wire wr_resp = do_write & wr_map & wr_off == cirp_pkg::OFF_RESP;
  wire wr_stat = do_write & wr_map & wr_off == cirp_pkg::OFF_STAT;
  wire wr_clr = do_write & wr_map & wr_off == cirp_pkg::OFF_CLR;
  wire [3:0] rd_off = word_off(s_axi_araddr);
  wire [31:0] ctrl_word = {
    {(32-cirp_pkg::CTRL_VOFF_LSB-cirp_pkg::VOFF_W){1'b0}}, link.voffset, 3'h0,
    ~link.avec_n, ~link.mcp_n, ~link.nmi_n, ~link.critint_n, ~link.extint_n};
  wire [31:0] stat_word = {28'h0, link.wakeup, link.rsrv, iack_seen, link.ipend};
  wire [31:0] rd_word = rd_off == cirp_pkg::OFF_CTRL ? ctrl_word :
    rd_off == cirp_pkg::OFF_RESP ? {29'h0, resp_code} :
    rd_off == cirp_pkg::OFF_STAT ? stat_word : 32'h0;

  // ========================================
  // axi4-lite slave; a ready low means that channel's item is held
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cirp_pkg::AXI_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= cirp_pkg::AXI_OKAY;
      s_axi_rdata <= '0;
      aw_addr <= '0;
      w_data <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? cirp_pkg::AXI_OKAY : cirp_pkg::AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= mapped(s_axi_araddr) ? rd_word : 32'h0;
        s_axi_rresp <= mapped(s_axi_araddr) ? cirp_pkg::AXI_OKAY : cirp_pkg::AXI_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ========================================
  // request pins, held by software until the source is serviced
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      link.extint_n <= cirp_pkg::PIN_NEGATED_N;
      link.critint_n <= cirp_pkg::PIN_NEGATED_N;
      link.nmi_n <= cirp_pkg::PIN_NEGATED_N;
      link.mcp_n <= cirp_pkg::PIN_NEGATED_N;
      link.avec_n <= cirp_pkg::PIN_NEGATED_N;
      link.voffset <= cirp_pkg::VOFF_RESET;
      resp_code <= cirp_pkg::RESP_OKAY;
      link.rsrv_clr <= 1'b0;
      iack_seen <= 1'b0;
    end
    else
    begin
      // one write moves all pins, so avec and offset come with the request
      if (wr_ctrl)
      begin
        link.extint_n <= ~w_data[cirp_pkg::CTRL_EXT];
        link.critint_n <= ~w_data[cirp_pkg::CTRL_CRIT];
        link.nmi_n <= ~w_data[cirp_pkg::CTRL_NMI];
        link.mcp_n <= ~w_data[cirp_pkg::CTRL_MCP];
        link.avec_n <= ~w_data[cirp_pkg::CTRL_AVEC];
        link.voffset <= w_data[cirp_pkg::CTRL_VOFF_LSB +: cirp_pkg::VOFF_W];
      end
      if (wr_resp)
        resp_code <= w_data[cirp_pkg::RESP_W-1:0];
      link.rsrv_clr <= wr_clr & w_data[cirp_pkg::CLR_RSRV];
      // an acknowledge in the clearing cycle wins
      iack_seen <= link.iack | (iack_seen & ~(wr_stat & w_data[cirp_pkg::STAT_IACK]));
    end
  end

  // ========================================
  // data transfer terminations
  cirp_pkg::cirp_resp_state_t rs;
  wire two_cycle = resp_code == cirp_pkg::RESP_ERROR || resp_code == cirp_pkg::RESP_XFAIL;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rs <= cirp_pkg::HS_IDLE;
      link.hready <= 1'b0;
      link.hresp <= cirp_pkg::RESP_OKAY;
    end
    else
    begin
      case (rs)
        cirp_pkg::HS_IDLE:
          if (link.d_req)
          begin
            // xfail only means something on an exclusive transfer
            link.hresp <= (resp_code == cirp_pkg::RESP_XFAIL && !link.d_excl) ? cirp_pkg::RESP_OKAY : resp_code;
            link.hready <= ~(two_cycle && (link.d_excl || resp_code == cirp_pkg::RESP_ERROR));
            rs <= (two_cycle && (link.d_excl || resp_code == cirp_pkg::RESP_ERROR)) ? cirp_pkg::HS_PRE :
              cirp_pkg::HS_DONE;
          end
        cirp_pkg::HS_PRE:
        begin
          link.hready <= 1'b1;
          rs <= cirp_pkg::HS_DONE;
        end
        cirp_pkg::HS_DONE:
        begin
          link.hready <= 1'b0;
          link.hresp <= cirp_pkg::RESP_OKAY;
          rs <= cirp_pkg::HS_IDLE;
        end
        default:
          rs <= cirp_pkg::HS_IDLE;
      endcase
    end
  end
endmodule

/* logic/cirp_pkg.sv */
// shared constants and types for the interrupt and reservation port
package cirp_pkg;
  // ========================================
  // widths
  localparam int VOFF_W = 10;
  localparam int BASE_W = 20;
  localparam int RESP_W = 3;
  // ========================================
  // data bus response codes
  localparam logic [2:0] RESP_OKAY = 3'h0;
  localparam logic [2:0] RESP_ERROR = 3'h1;
  localparam logic [2:0] RESP_XFAIL = 3'h4;
  // ========================================
  // pin levels after reset, and the zero low address bits
  localparam logic PIN_NEGATED_N = 1'b1;
  localparam logic [VOFF_W-1:0] VOFF_RESET = 10'h000;
  localparam logic [1:0] ADDR_LOW_ZERO = 2'h0;
  // ========================================
  // controller register map, byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_RESP = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  localparam logic [3:0] OFF_CLR = 4'hC;
  // control register fields
  localparam int CTRL_EXT = 0;
  localparam int CTRL_CRIT = 1;
  localparam int CTRL_NMI = 2;
  localparam int CTRL_MCP = 3;
  localparam int CTRL_AVEC = 4;
  localparam int CTRL_VOFF_LSB = 8;
  // status and clear register fields
  localparam int STAT_IPEND = 0;
  localparam int STAT_IACK = 1;
  localparam int STAT_RSRV = 2;
  localparam int STAT_WAKE = 3;
  localparam int CLR_RSRV = 0;
  // axi responses
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // ========================================
  // types
  typedef enum logic [2:0] {
    CS_RUN = 3'b000,
    CS_WAIT = 3'b001,
    CS_HALT = 3'b010,
    CS_STOP = 3'b011,
    CS_DEBUG = 3'b100
  } cirp_core_state_t;
  typedef enum logic [2:0] {
    CL_NONE = 3'b000,
    CL_NMI = 3'b001,
    CL_MCHK = 3'b010,
    CL_CRIT = 3'b011,
    CL_EXT = 3'b100
  } cirp_class_t;
  typedef enum logic [0:0] {
    BS_IDLE = 1'b0,
    BS_WAIT = 1'b1
  } cirp_bus_state_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_PRE = 2'b01,
    HS_DONE = 2'b10
  } cirp_resp_state_t;
endpackage

/* logic/cirp_if.sv */
// link between the core port and the interrupt controller end
`timescale 1ns/1ps
interface cirp_if;
  // interrupt requests, active low
  logic extint_n;
  logic critint_n;
  logic nmi_n;
  logic mcp_n;
  logic avec_n;
  logic [cirp_pkg::VOFF_W-1:0] voffset;
  // core status
  logic ipend;
  logic iack;
  logic wakeup;
  // reservation
  logic rsrv;
  logic rsrv_clr;
  // data bus termination
  logic d_req;
  logic d_excl;
  logic hready;
  logic [cirp_pkg::RESP_W-1:0] hresp;

  modport dev (
    input extint_n, critint_n, nmi_n, mcp_n, avec_n, voffset, rsrv_clr, hready, hresp,
    output ipend, iack, wakeup, rsrv, d_req, d_excl
  );
  modport ctl (
    output extint_n, critint_n, nmi_n, mcp_n, avec_n, voffset, rsrv_clr, hready, hresp,
    input ipend, iack, wakeup, rsrv, d_req, d_excl
  );
endinterface

/* logic/cirp_edge_det.sv */
// falling-edge catcher for transition-sensitive active-low requests
`timescale 1ns/1ps
module cirp_edge_det (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request pin and qualifiers
  input wire logic sample_en,
  input wire logic pin_n,
  input wire logic take,
  // pending request
  output logic pending
);
  // ========================================
  // two consecutive samples
  logic prev_n;
  wire edge_seen = sample_en & prev_n & ~pin_n;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prev_n <= cirp_pkg::PIN_NEGATED_N;
      pending <= 1'b0;
    end
    else
    begin
      // frozen while not sampling, so a low held through a stall is no new edge
      if (sample_en)
        prev_n <= pin_n;
      // a new edge wins over a take
      pending <= edge_seen | (pending & ~take);
    end
  end
endmodule

/* logic/cirp_core_port.sv */
// core end: interrupt request port, reservation status and bus termination
//
// Summary of operation
// - Error and xfail responses take two cycles
// - Response 100 means failed exclusive store
// - Controller holds level requests and vectors
// - Requests stay stable; withdrawal may misfire
// - Low external request acts when enabled
// - Low critical request acts when enabled
// - Non-maskable request taken on falling transition
// - Halted or stopped: pending and wakeup raised
// - Debug state: non-maskable not recognised
// - Pending is combinational from qualified requests
// - Pending does not mean processing began
// - Non-maskable level always raises pending
// - Autovector picks internal vector register
// - Autovector level valid while request asserted
// - Offset lands at bits 11:2, low zero
// - Offset valid with request unless autovector
// - Acknowledge follows sampling of vector inputs
// - Machine check gated, transition detected
// - Machine check not sampled halted, stopped, debug
// - Reservation set after load-and-reserve
// - Reservation clear input drops reservation
// - Exclusive store failure indicated from response
`timescale 1ns/1ps
module cirp_core_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // link to the interrupt controller and system logic
  cirp_if.dev link,
  // core configuration
  input wire logic external_irq_enable,
  input wire logic critical_irq_enable,
  input wire logic machine_check_pin_enable,
  input wire logic [cirp_pkg::VOFF_W-1:0] external_vector_reg,
  input wire logic [cirp_pkg::VOFF_W-1:0] critical_vector_reg,
  input wire logic [cirp_pkg::BASE_W-1:0] handler_base,
  // timer facility requests and enables
  input wire logic wdog_irq,
  input wire logic wdog_en,
  input wire logic fit_irq,
  input wire logic fit_en,
  input wire logic dec_irq,
  input wire logic dec_en,
  // core state
  input wire cirp_pkg::cirp_core_state_t core_state,
  input wire logic exc_ready,
  // exception handoff
  output logic exc_take,
  output cirp_pkg::cirp_class_t exc_class,
  output logic [31:0] exc_addr,
  // reservation and data transfers
  input wire logic lwarx_done,
  input wire logic bus_start,
  input wire logic bus_excl,
  output logic bus_done,
  output logic bus_err,
  output logic stcx_ok,
  output logic store_xfail_n
);
  // ========================================
  // vector selection
  function automatic logic [cirp_pkg::VOFF_W-1:0] pick_offset(
    input logic avec_n,
    input logic [cirp_pkg::VOFF_W-1:0] internal,
    input logic [cirp_pkg::VOFF_W-1:0] external
  );
    pick_offset = avec_n ? external : internal;
  endfunction

  // ========================================
  // request qualification
  wire ext_req = ~link.extint_n & external_irq_enable;
  wire crit_req = ~link.critint_n & critical_irq_enable;
  wire timer_req = (wdog_irq & wdog_en) | (fit_irq & fit_en) | (dec_irq & dec_en);
  wire in_debug = core_state == cirp_pkg::CS_DEBUG;
  wire clocks_off = core_state == cirp_pkg::CS_HALT || core_state == cirp_pkg::CS_STOP;
  wire nmi_sample = ~in_debug;
  // waiting keeps sampling; halted, stopped and debug do not
  wire mcp_sample = machine_check_pin_enable & ~in_debug & ~clocks_off;
  wire can_take = exc_ready & ~exc_take & ~in_debug & ~clocks_off;
  wire nmi_pend;
  wire mcp_pend;
  wire take_nmi = can_take & nmi_pend;
  wire take_mcp = can_take & ~nmi_pend & mcp_pend;
  wire take_crit = can_take & ~nmi_pend & ~mcp_pend & crit_req;
  wire take_ext = can_take & ~nmi_pend & ~mcp_pend & ~crit_req & ext_req;
  wire take_any = take_nmi | take_mcp | take_crit | take_ext;
  // avec and offset are looked at only in the take cycle
  wire [cirp_pkg::VOFF_W-1:0] crit_off = pick_offset(link.avec_n, critical_vector_reg, link.voffset);
  wire [cirp_pkg::VOFF_W-1:0] ext_off = pick_offset(link.avec_n, external_vector_reg, link.voffset);
  wire [cirp_pkg::VOFF_W-1:0] take_off = take_crit ? crit_off : take_ext ? ext_off : cirp_pkg::VOFF_RESET;
  wire [31:0] next_exc_addr = {handler_base, take_off, cirp_pkg::ADDR_LOW_ZERO};
  wire cirp_pkg::cirp_class_t next_class = take_nmi ? cirp_pkg::CL_NMI :
    take_mcp ? cirp_pkg::CL_MCHK :
    take_crit ? cirp_pkg::CL_CRIT :
    take_ext ? cirp_pkg::CL_EXT : cirp_pkg::CL_NONE;

  // ========================================
  // transition detection
  cirp_edge_det u_nmi_det (
    .ref_clk(ref_clk),
    .rst(rst),
    .sample_en(nmi_sample),
    .pin_n(link.nmi_n),
    .take(take_nmi),
    .pending(nmi_pend)
  );

  cirp_edge_det u_mcp_det (
    .ref_clk(ref_clk),
    .rst(rst),
    .sample_en(mcp_sample),
    .pin_n(link.mcp_n),
    .take(take_mcp),
    .pending(mcp_pend)
  );

  // ========================================
  // pending and wakeup
  // pending flags a recognised request; the take may wait on exc_ready
  assign link.ipend = ext_req | crit_req | ~link.nmi_n | timer_req;
  // with clocks off the level itself must wake the system
  assign link.wakeup = link.ipend | (clocks_off & ~link.nmi_n);

  // ========================================
  // exception take and acknowledge
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      exc_take <= 1'b0;
      exc_class <= cirp_pkg::CL_NONE;
      exc_addr <= '0;
      link.iack <= 1'b0;
    end
    else
    begin
      exc_take <= take_any;
      exc_class <= next_class;
      if (take_any)
        exc_addr <= next_exc_addr;
      link.iack <= take_crit | take_ext;
    end
  end

  // ========================================
  // data transfer termination
  cirp_pkg::cirp_bus_state_t bus_state;
  cirp_pkg::cirp_bus_state_t next_bus_state;
  wire term = bus_state == cirp_pkg::BS_WAIT && link.hready;
  wire resp_err = link.hresp == cirp_pkg::RESP_ERROR;
  // xfail is a failed conditional store, not a bus error
  wire resp_xfail = link.hresp == cirp_pkg::RESP_XFAIL;
  wire excl_end = term & link.d_excl;

  always_comb
  begin
    next_bus_state = bus_state;
    case (bus_state)
      cirp_pkg::BS_IDLE:
        if (bus_start)
          next_bus_state = cirp_pkg::BS_WAIT;
      cirp_pkg::BS_WAIT:
        if (link.hready)
          next_bus_state = cirp_pkg::BS_IDLE;
      default:
        next_bus_state = cirp_pkg::BS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bus_state <= cirp_pkg::BS_IDLE;
      link.d_req <= 1'b0;
      link.d_excl <= 1'b0;
      bus_done <= 1'b0;
      bus_err <= 1'b0;
      stcx_ok <= 1'b0;
      store_xfail_n <= 1'b1;
    end
    else
    begin
      bus_state <= next_bus_state;
      if (bus_state == cirp_pkg::BS_IDLE && bus_start)
      begin
        link.d_req <= 1'b1;
        link.d_excl <= bus_excl;
      end
      else if (term)
      begin
        link.d_req <= 1'b0;
        link.d_excl <= 1'b0;
      end
      // code read only in the hready cycle; held there since the cycle before
      bus_done <= term;
      bus_err <= term & resp_err;
      stcx_ok <= excl_end & ~resp_err & ~resp_xfail;
      store_xfail_n <= ~(excl_end & resp_xfail);
    end
  end

  // ========================================
  // reservation flag
  // a new reservation wins over a clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      link.rsrv <= 1'b0;
    else
      link.rsrv <= lwarx_done | (link.rsrv & ~link.rsrv_clr & ~excl_end);
  end
endmodule

/* sim/cirp_chk.sv */
// concurrent checks on the core-to-controller link
`timescale 1ns/1ps
// ========================================
// link checker
module cirp_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // requests
  input wire logic extint_n,
  input wire logic critint_n,
  input wire logic nmi_n,
  // core status
  input wire logic ipend,
  input wire logic iack,
  input wire logic wakeup,
  // data termination
  input wire logic d_req,
  input wire logic d_excl,
  input wire logic hready,
  input wire logic [cirp_pkg::RESP_W-1:0] hresp
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ========================================
  // bus termination
  resp_held_a: assert property (hready && hresp != cirp_pkg::RESP_OKAY |-> $stable(hresp))
    else $error("code moved at ready");
  resp_lead_a: assert property (d_req && !hready && hresp != cirp_pkg::RESP_OKAY |=> hready)
    else $error("code not followed by ready");
  ready_pulse_a: assert property (hready |=> !hready)
    else $error("ready too long");
  ready_bound_a: assert property ($rose(d_req) |-> ##[1:3] hready)
    else $error("transfer not ended");
  ready_req_a: assert property (hready |-> d_req)
    else $error("ready with no transfer");
  xfail_excl_a: assert property (hready && !d_excl |-> hresp != cirp_pkg::RESP_XFAIL)
    else $error("xfail on plain transfer");
  // ========================================
  // interrupt status
  nmi_pend_a: assert property (!nmi_n |-> ipend)
    else $error("nmi without pending");
  pend_wake_a: assert property (ipend |-> wakeup)
    else $error("no wakeup");
  iack_pulse_a: assert property (iack |=> !iack)
    else $error("iack too long");
  iack_cause_a: assert property (iack |-> $past(extint_n) == 1'b0 || $past(critint_n) == 1'b0)
    else $error("iack with no request");
  // scenarios reached
  cover property (iack);
  cover property (hready && hresp == cirp_pkg::RESP_XFAIL);
  cover property (hready && hresp == cirp_pkg::RESP_ERROR);
  cover property (!nmi_n && ipend);
endmodule

/* sim/core_interrupt_reservation_port_tb.sv */
// self-checking bench for core port and controller end
`timescale 1ns/1ps
// ========================================
// bench top
module core_interrupt_reservation_port_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic external_irq_enable = 1'b0, critical_irq_enable = 1'b0, machine_check_pin_enable = 1'b0;
  logic [9:0] external_vector_reg = '0, critical_vector_reg = '0, v = '0;
  logic [19:0] handler_base = '0;
  logic [5:0] tmr = '0;
  cirp_pkg::cirp_core_state_t core_state = cirp_pkg::CS_RUN;
  logic exc_ready = 1'b1, lwarx_done = 1'b0, bus_start = 1'b0, bus_excl = 1'b0;
  logic exc_take, bus_done, bus_err, stcx_ok, store_xfail_n, got_iack;
  cirp_pkg::cirp_class_t exc_class, got_class;
  logic [31:0] exc_addr, got_addr, rd, awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [2:0] codes [3] = '{cirp_pkg::RESP_OKAY, cirp_pkg::RESP_ERROR, cirp_pkg::RESP_XFAIL};
  int num_errors = 0, checks_done = 0, take_cnt = 0, dummy;

  cirp_if link ();
  cirp_core_port cirp_core_port_i (.ref_clk(ref_clk), .rst(rst), .link(link.dev),
    .external_irq_enable(external_irq_enable), .critical_irq_enable(critical_irq_enable),
    .machine_check_pin_enable(machine_check_pin_enable), .external_vector_reg(external_vector_reg),
    .critical_vector_reg(critical_vector_reg), .handler_base(handler_base),
    .wdog_irq(tmr[5]), .wdog_en(tmr[4]), .fit_irq(tmr[3]), .fit_en(tmr[2]), .dec_irq(tmr[1]), .dec_en(tmr[0]),
    .core_state(core_state), .exc_ready(exc_ready), .exc_take(exc_take), .exc_class(exc_class),
    .exc_addr(exc_addr), .lwarx_done(lwarx_done), .bus_start(bus_start), .bus_excl(bus_excl),
    .bus_done(bus_done), .bus_err(bus_err), .stcx_ok(stcx_ok), .store_xfail_n(store_xfail_n));
  cirp_ctrl_end cirp_ctrl_end_i (.ref_clk(ref_clk), .rst(rst), .link(link.ctl),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  cirp_chk cirp_chk_i (.ref_clk(ref_clk), .rst(rst), .extint_n(link.extint_n), .critint_n(link.critint_n),
    .nmi_n(link.nmi_n), .ipend(link.ipend), .iack(link.iack), .wakeup(link.wakeup), .d_req(link.d_req),
    .d_excl(link.d_excl), .hready(link.hready), .hresp(link.hresp));

  initial forever #5 ref_clk = ~ref_clk;
  // retakes of a held level overwrite the same values
  always @(posedge ref_clk)
  begin
    if (exc_take === 1'b1)
    begin
      take_cnt <= take_cnt + 1;
      got_class <= exc_class;
      got_addr <= exc_addr;
      got_iack <= link.iack;
    end
  end
  // ========================================
  // shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic tmr_pend(input logic [5:0] t);
    return (t[5] & t[4]) | (t[3] & t[2]) | (t[1] & t[0]);
  endfunction
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task give_up;
    num_errors++;
    print_verdict();
  endtask
  task axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 40) give_up();
    r = bresp;
    bready <= 1'b0;
  endtask
  task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 40) give_up();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // pins = {avec, mcp, nmi, crit, ext}; go releases a stalled core
  task irq_case(input logic [4:0] pins, input cirp_pkg::cirp_core_state_t st, input logic go,
    input logic pend, input int cls, input logic [9:0] off);
    int n0;
    int n;
    @(posedge ref_clk);
    n0 = take_cnt;
    core_state <= st;
    axi_wr(32'(cirp_pkg::OFF_CTRL), {14'h0, v, 3'h0, pins}, rsp);
    repeat (3) @(posedge ref_clk);
    #1 chk(link.ipend, pend);
    chk(link.wakeup, pend);
    if (go)
    begin
      repeat (6) @(posedge ref_clk);
      #1 chk(take_cnt - n0, 0);
      @(posedge ref_clk) core_state <= cirp_pkg::CS_RUN;
    end
    for (n = 0; n < 12 && take_cnt == n0; n++) @(posedge ref_clk);
    if (cls == 0)
      chk(take_cnt - n0, 0);
    else
    begin
      if (take_cnt == n0) give_up();
      chk(got_class, cls);
      chk(got_addr, {handler_base, off, cirp_pkg::ADDR_LOW_ZERO});
      chk(got_iack, cls >= int'(cirp_pkg::CL_CRIT));
    end
    axi_wr(32'(cirp_pkg::OFF_CTRL), 32'h0, rsp);
    core_state <= cirp_pkg::CS_RUN;
    repeat (4) @(posedge ref_clk);
  endtask
  task bus_case(input logic excl, input logic [2:0] code);
    int n;
    axi_wr(32'(cirp_pkg::OFF_RESP), {29'h0, code}, rsp);
    @(posedge ref_clk) lwarx_done <= 1'b1;
    @(posedge ref_clk)
    begin
      lwarx_done <= 1'b0;
      bus_start <= 1'b1;
      bus_excl <= excl;
    end
    @(posedge ref_clk) bus_start <= 1'b0;
    #1 chk(link.rsrv, 1'b1);
    for (n = 0; n < 20; n++)
    begin
      @(posedge ref_clk);
      #1 if (bus_done === 1'b1) break;
    end
    if (n == 20) give_up();
    chk(bus_err, code == cirp_pkg::RESP_ERROR);
    chk(store_xfail_n, !(excl && code == cirp_pkg::RESP_XFAIL));
    chk(stcx_ok, excl && code == cirp_pkg::RESP_OKAY);
    chk(link.rsrv, !excl);
    axi_wr(32'(cirp_pkg::OFF_CLR), 32'h1, rsp);
    repeat (2) @(posedge ref_clk);
    #1 chk(link.rsrv, 1'b0);
  endtask
  // ========================================
  // main sequence
  initial
  begin
    dummy = $urandom(23);
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 chk({link.extint_n, link.critint_n, link.nmi_n, link.mcp_n, link.avec_n}, 5'h1F);
    chk({link.iack, link.rsrv, link.hready}, 3'h0);
    axi_rd(32'(cirp_pkg::OFF_STAT), rd, rsp);
    chk({rsp, rd}, {cirp_pkg::AXI_OKAY, 32'h0});
    axi_rd(32'h10, rd, rsp); // unmapped read refused
    chk({rsp, rd}, {cirp_pkg::AXI_SLVERR, 32'h0});
    axi_wr(32'h20, 32'h1F, rsp);
    chk(rsp, cirp_pkg::AXI_SLVERR);
    repeat (2)
    begin
      v = 10'($urandom);
      @(posedge ref_clk);
      handler_base <= 20'($urandom);
      external_vector_reg <= 10'($urandom);
      critical_vector_reg <= 10'($urandom);
      {external_irq_enable, critical_irq_enable, machine_check_pin_enable} <= 3'h7;
      @(posedge ref_clk);
      irq_case(5'b00001, cirp_pkg::CS_RUN, 0, 1, cirp_pkg::CL_EXT, v);
      irq_case(5'b10001, cirp_pkg::CS_RUN, 0, 1, cirp_pkg::CL_EXT, external_vector_reg);
      irq_case(5'b00010, cirp_pkg::CS_WAIT, 0, 1, cirp_pkg::CL_CRIT, v);
      irq_case(5'b10010, cirp_pkg::CS_RUN, 0, 1, cirp_pkg::CL_CRIT, critical_vector_reg);
      irq_case(5'b00100, cirp_pkg::CS_RUN, 0, 1, cirp_pkg::CL_NMI, 10'h0);
      irq_case(5'b00100, cirp_pkg::CS_HALT, 1, 1, cirp_pkg::CL_NMI, 10'h0);
      irq_case(5'b00100, cirp_pkg::CS_DEBUG, 1, 1, cirp_pkg::CL_NMI, 10'h0);
      irq_case(5'b01000, cirp_pkg::CS_WAIT, 0, 0, cirp_pkg::CL_MCHK, 10'h0);
      irq_case(5'b01000, cirp_pkg::CS_STOP, 0, 0, 0, 10'h0);
      {external_irq_enable, critical_irq_enable, machine_check_pin_enable} <= 3'h0;
      irq_case(5'b00001, cirp_pkg::CS_RUN, 0, 0, 0, 10'h0);
      irq_case(5'b00010, cirp_pkg::CS_RUN, 0, 0, 0, 10'h0);
      irq_case(5'b01000, cirp_pkg::CS_RUN, 0, 0, 0, 10'h0);
      irq_case(5'b00100, cirp_pkg::CS_RUN, 0, 1, cirp_pkg::CL_NMI, 10'h0);
    end
    axi_rd(32'(cirp_pkg::OFF_STAT), rd, rsp);
    chk(rd, 32'h2);
    axi_wr(32'(cirp_pkg::OFF_STAT), 32'h2, rsp);
    axi_rd(32'(cirp_pkg::OFF_STAT), rd, rsp);
    chk(rd, 32'h0);
    repeat (8)
    begin
      @(posedge ref_clk) tmr <= 6'($urandom);
      @(posedge ref_clk);
      #1 chk(link.ipend, tmr_pend(tmr));
    end
    @(posedge ref_clk) tmr <= 6'h0;
    for (int e = 0; e < 2; e++)
      for (int c = 0; c < 3; c++)
        bus_case(e[0], codes[c]);
    print_verdict();
  end
endmodule
